// ==== src/smse_top.sv ====
// servo mode selection and servo enable gating
`timescale 1ns/100ps
module smse_top
    import smse_pkg::*;
#(
    parameter int SPD_W = smse_pkg::SPEED_W
) (
    input  wire logic                       clock,                // 100 MHz clock
    input  wire logic                       reset,                // power cycle, async high
    input  wire logic [smse_pkg::MODE_W-1:0] control_mode_param,  // mode setting
    input  wire logic                       enable_source_param,  // enable source digit
    input  wire logic                       servo_enable_n_in,    // pin, active low
    input  wire logic                       prop_control_in,      // pin, active low
    input  wire logic                       fwd_current_limit_in, // pin, active low
    input  wire logic                       rev_current_limit_in, // pin, active low
    input  wire logic                       mode_switch_in,       // pin, switch-mode select
    input  wire logic                       drive_ready,          // internal ready condition
    input  wire logic                       ref_pulse_in,         // pin, reference pulse
    input  wire logic                       ref_dir_in,           // pin, pulse direction
    input  wire logic [SPD_W-1:0]           analog_speed_ref,     // sampled speed reference
    input  wire logic [SPD_W-1:0]           analog_torque_ref,    // sampled torque reference
    input  wire logic [SPD_W-1:0]           preset_speed_1,       // stored speed 1
    input  wire logic [SPD_W-1:0]           preset_speed_2,       // stored speed 2
    input  wire logic [SPD_W-1:0]           preset_speed_3,       // stored speed 3
    output logic                            servo_ready_out,      // ready output
    output logic                            motor_power_on,       // motor excitation
    output logic [2:0]                      active_loop,          // loop in use
    output logic [SPD_W-1:0]                speed_command,        // speed loop command
    output logic [SPD_W-1:0]                torque_command,       // torque loop command
    output logic [smse_pkg::PULSE_W-1:0]    position_count,       // accumulated position
    output logic                            pulse_event           // one reference pulse
);
    //----------------------------------------
    // input synchronisers
    //----------------------------------------
    logic [6:0] pins_sync;

    smse_sync #(.WIDTH(7)) u_sync (
        .clock (clock),
        .reset (reset),
        .din   ({servo_enable_n_in, prop_control_in, fwd_current_limit_in,
                 rev_current_limit_in, mode_switch_in, ref_pulse_in, ref_dir_in}),
        .dout  (pins_sync)
    );

    logic en_n_s;
    logic pcon_s;
    logic pcl_s;
    logic ncl_s;
    logic sw_s;
    logic pulse_s;
    logic dir_s;
    assign {en_n_s, pcon_s, pcl_s, ncl_s, sw_s, pulse_s, dir_s} = pins_sync;

    //----------------------------------------
    // state
    //----------------------------------------
    typedef struct packed {
        logic                  loaded;
        logic [MODE_W-1:0]     mode;
        logic                  en_src;
        logic                  pulse_d;
        logic                  ready;
        logic                  power;
        smse_loop_type         loop;
        logic [SPD_W-1:0]      speed;
        logic [SPD_W-1:0]      torque;
        logic [PULSE_W-1:0]    pos;
        logic                  pev;
    } smse_state_type;

    smse_state_type state_reg;
    smse_state_type state_next;

    function automatic smse_loop_type base_loop(input logic [MODE_W-1:0] m);
        unique case (m)
            MODE_SPEED_ANALOG: base_loop = SMSE_ANALOG_SPEED;
            MODE_POSITION:     base_loop = SMSE_POSITION;
            MODE_TORQUE:       base_loop = SMSE_TORQUE;
            MODE_CONTACT:      base_loop = SMSE_CONTACT;
            default:           base_loop = SMSE_ILLEGAL;
        endcase
    endfunction : base_loop

    //----------------------------------------
    // next state
    //----------------------------------------
    logic              rise;
    logic [1:0]        sel;
    logic [MODE_W-1:0] sw_code;
    smse_loop_type     loop_sel;
    logic              want_on;

    always_comb begin
        state_next = state_reg;
        rise       = pulse_s && !state_reg.pulse_d;
        sel        = 2'h0;
        sw_code    = '0;
        loop_sel   = base_loop(state_reg.mode);
        want_on    = 1'b0;
        state_next.pulse_d = pulse_s;
        state_next.pev     = 1'b0;

        //----------------------------------------
        // settings, taken once after power-up only
        //----------------------------------------
        if (!state_reg.loaded) begin
            state_next.loaded = 1'b1;
            state_next.mode   = control_mode_param;
            state_next.en_src = enable_source_param;
        end

        //----------------------------------------
        // loop selection
        //----------------------------------------
        // switching modes: switch input picks pair member
        if (state_reg.mode >= MODE_SWITCH_FIRST && state_reg.mode <= MODE_SWITCH_LAST) begin
            sw_code  = MODE_W'(2'(state_reg.mode - MODE_SWITCH_FIRST) ^ {1'b0, sw_s});
            loop_sel = base_loop(sw_code);
        end
        if (!state_reg.loaded) begin
            loop_sel = SMSE_ILLEGAL;
        end
        state_next.loop  = loop_sel;

        //----------------------------------------
        // ready and motor power gating
        //----------------------------------------
        state_next.ready = drive_ready && state_reg.loaded;
        if (state_reg.en_src == ENABLE_AUTO) begin
            want_on = state_reg.ready;
        end else begin
            want_on = !en_n_s;
        end
        state_next.power = want_on && state_reg.ready && drive_ready;

        //----------------------------------------
        // commands, only while powered last cycle
        //----------------------------------------
        state_next.speed  = '0;
        state_next.torque = '0;
        if (state_reg.power) begin
            unique case (loop_sel)
                SMSE_ANALOG_SPEED: state_next.speed = analog_speed_ref;
                SMSE_TORQUE:       state_next.torque = analog_torque_ref;
                SMSE_CONTACT: begin
                    // active-low inputs; limits pick speed, prop negates it
                    sel = {!pcl_s, !ncl_s};
                    unique case (sel)
                        2'h1:    state_next.speed = preset_speed_1;
                        2'h2:    state_next.speed = preset_speed_2;
                        2'h3:    state_next.speed = preset_speed_3;
                        default: state_next.speed = '0;
                    endcase
                    if (!pcon_s && sel != 2'h0) begin
                        state_next.speed = SPD_W'(0) - state_next.speed;
                    end
                end
                SMSE_POSITION: begin
                    if (rise) begin
                        state_next.pev = 1'b1;
                        state_next.pos = dir_s ? state_reg.pos - 32'h1
                                               : state_reg.pos + 32'h1;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg        <= '0;
            state_reg.mode   <= MODE_RESET;
            state_reg.en_src <= ENABLE_SRC_RESET;
            state_reg.loop   <= SMSE_ILLEGAL;
        end else begin
            state_reg <= state_next;
        end
    end

    //----------------------------------------
    // outputs
    //----------------------------------------
    assign servo_ready_out = state_reg.ready;
    assign motor_power_on  = state_reg.power;
    assign active_loop     = state_reg.loop;
    assign speed_command   = state_reg.speed;
    assign torque_command  = state_reg.torque;
    assign position_count  = state_reg.pos;
    assign pulse_event     = state_reg.pev;
endmodule : smse_top

// ==== inc/smse_pkg.sv ====
// constants and types for servo mode select and enable
package smse_pkg;
    localparam int MODE_W          = 4;
    localparam int SPEED_W         = 16;
    localparam int PULSE_W         = 32;
    localparam logic [3:0] MODE_SPEED_ANALOG = 4'h0;
    localparam logic [3:0] MODE_POSITION     = 4'h1;
    localparam logic [3:0] MODE_TORQUE       = 4'h2;
    localparam logic [3:0] MODE_CONTACT      = 4'h3;
    localparam logic [3:0] MODE_SWITCH_FIRST = 4'h4;
    localparam logic [3:0] MODE_SWITCH_LAST  = 4'hE;
    localparam logic       ENABLE_EXTERNAL   = 1'h0;
    localparam logic       ENABLE_AUTO       = 1'h1;
    localparam logic [3:0] MODE_RESET        = 4'h0;
    localparam logic       ENABLE_SRC_RESET  = 1'h0;
    localparam int         SYNC_STAGES       = 2;

    typedef enum logic [2:0] {
        SMSE_ANALOG_SPEED = 3'h0,
        SMSE_POSITION     = 3'h1,
        SMSE_TORQUE       = 3'h3,
        SMSE_CONTACT      = 3'h2,
        SMSE_SWITCHING    = 3'h6,
        SMSE_ILLEGAL      = 3'h7
    } smse_loop_type;
endpackage : smse_pkg

// ==== src/smse_sync.sv ====
// two-stage synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module smse_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,   // system clock
    input  wire logic             reset,   // async reset, high
    input  wire logic [WIDTH-1:0] din,     // asynchronous pins
    output logic      [WIDTH-1:0] dout     // synchronised pins
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } smse_sync_type;

    smse_sync_type state_reg;
    smse_sync_type state_next;

    always_comb begin
        state_next        = state_reg;
        state_next.stage1 = din;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign dout = state_reg.stage2;
endmodule : smse_sync

// ==== testbench/smse_assertions.sv ====
// port checks for mode select and enable
`timescale 1ns/100ps
module smse_assertions
    import smse_pkg::*;
#(
    parameter int SPD_W = 16
) (
    input wire logic             clock,               // clock
    input wire logic             reset,               // reset
    input wire logic [3:0]       control_mode_param,  // mode
    input wire logic             enable_source_param, // source
    input wire logic             servo_enable_n_in,   // enable pin
    input wire logic             drive_ready,         // ready
    input wire logic [SPD_W-1:0] analog_torque_ref,   // torque ref
    input wire logic             motor_power_on,      // power
    input wire logic [2:0]       active_loop,         // loop
    input wire logic [SPD_W-1:0] torque_command,      // torque out
    input wire logic [31:0]      position_count,      // position
    input wire logic             pulse_event          // pulse
);
    logic [1:0] cnt;
    logic [3:0] mode_cap;
    logic       src_cap;
    // settings seen at first edge
    always_ff @(posedge clock or posedge reset) begin
        if (reset) cnt <= 2'h0;
        else if (cnt != 2'h3) cnt <= cnt + 2'h1;
    end
    always_ff @(posedge clock) begin
        if (cnt == 2'h0) {mode_cap, src_cap} <= {control_mode_param, enable_source_param};
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_power_ready: assert property (motor_power_on |-> $past(drive_ready))
        else $error("power without ready");
    a_ext_on: assert property ((cnt == 2'h3 && !src_cap &&
        !servo_enable_n_in && drive_ready) [*4] |=> motor_power_on)
        else $error("enable low but no power");
    a_ext_off: assert property ((cnt == 2'h3 && !src_cap &&
        servo_enable_n_in) [*4] |=> !motor_power_on)
        else $error("enable high but powered");
    a_auto_on: assert property ((cnt == 2'h3 && src_cap && drive_ready) [*4]
        |=> motor_power_on)
        else $error("auto source not powered");
    a_loop_basic: assert property (motor_power_on && cnt == 2'h3
        && mode_cap < 4'h4 |-> active_loop == {1'b0, mode_cap[1], mode_cap[1] ^ mode_cap[0]})
        else $error("wrong loop for mode");
    a_count_hold: assert property (!pulse_event |-> $stable(position_count))
        else $error("position moved without pulse");
    a_count_step: assert property (pulse_event |-> active_loop == 3'h1 &&
        (position_count - $past(position_count) == 32'h1 ||
         $past(position_count) - position_count == 32'h1))
        else $error("pulse not one step");
    a_torque_follow: assert property ((motor_power_on && mode_cap == 4'h2 &&
        $stable(analog_torque_ref)) [*3] |-> torque_command == analog_torque_ref)
        else $error("torque command off");
endmodule : smse_assertions

bind smse_top smse_assertions #(.SPD_W(SPD_W)) u_chk (.clock, .reset, .control_mode_param,
    .enable_source_param, .servo_enable_n_in, .drive_ready, .analog_torque_ref, .motor_power_on,
    .active_loop, .torque_command, .position_count, .pulse_event);

// ==== testbench/smse_host_model.sv ====
// host controller driving enable and reference pulses
`timescale 1ns/100ps
module smse_host_model (
    input  wire logic   clock,                    // clock
    input  wire logic   run,                      // motion wanted
    output logic        servo_enable_n_in = 1'b1, // enable pin
    output logic        ref_pulse_in = 1'b0,      // pulse pin
    output logic [31:0] sent = 32'h0              // pulses sent
);
    int   hold = 0;
    logic go   = 1'b0;
    // run read at the edge, clear of the bench's own drive time
    always @(posedge clock) begin
        go = run;
        #1;
        if (go && hold < 12) hold <= hold + 1;
        else if (!go && hold > 0) hold <= hold - 1;
        servo_enable_n_in <= !go && hold == 0;
        ref_pulse_in <= go && hold >= 8 && !ref_pulse_in;
        if (go && hold >= 8 && !ref_pulse_in) sent <= sent + 32'h1;
    end
endmodule : smse_host_model

// ==== testbench/smse_top_bench.sv ====
// self-checking bench for mode select and enable
`timescale 1ns/100ps
module smse_top_bench;
    import smse_pkg::*;
    logic clock = 1'b0, reset = 1'b1, enable_source_param = 1'b0, drive_ready = 1'b0, run = 1'b0;
    logic prop_control_in = 1'b1, fwd_current_limit_in = 1'b1, rev_current_limit_in = 1'b1;
    logic mode_switch_in = 1'b0, ref_dir_in = 1'b0;
    logic [3:0] control_mode_param = 4'h0;
    logic [15:0] analog_speed_ref = 16'h1234, analog_torque_ref = 16'h0ABC;
    logic [15:0] preset_speed_1 = 16'h0100, preset_speed_2 = 16'h0200, preset_speed_3 = 16'h0300;
    logic servo_enable_n_in, ref_pulse_in, servo_ready_out, motor_power_on, pulse_event;
    logic [2:0] active_loop;
    logic [15:0] speed_command, torque_command, exp_speed;
    logic [31:0] position_count, sent, p0, p1;
    int fail_count = 0, n_tests = 0, cycles = 0;
    always #5 clock = ~clock;
    smse_host_model host (.clock, .run, .servo_enable_n_in, .ref_pulse_in, .sent);
    smse_top uut (.clock, .reset, .control_mode_param, .enable_source_param, .servo_enable_n_in,
        .prop_control_in, .fwd_current_limit_in, .rev_current_limit_in, .mode_switch_in,
        .drive_ready, .ref_pulse_in, .ref_dir_in, .analog_speed_ref, .analog_torque_ref,
        .preset_speed_1, .preset_speed_2, .preset_speed_3, .servo_ready_out, .motor_power_on,
        .active_loop, .speed_command, .torque_command, .position_count, .pulse_event);
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step
    task automatic power_up(input logic [3:0] m, input logic s);
        control_mode_param = m;
        enable_source_param = s;
        reset = 1'b1;
        step(6);
        reset = 1'b0;
        step(3);
    endtask : power_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end
    // --------------------------------------------
    // tests
    // --------------------------------------------
    initial begin
        power_up(4'h0, 1'b0);
        run = 1'b1;
        step(20);
        chk(motor_power_on, 1'b0);
        chk(servo_ready_out, 1'b0);
        drive_ready = 1'b1;
        step(8);
        chk(servo_ready_out, 1'b1);
        chk(motor_power_on, 1'b1);
        chk(speed_command, analog_speed_ref);
        run = 1'b0;
        step(20);
        chk(motor_power_on, 1'b0);
        chk(speed_command, 16'h0000);
        $display("test external enable done");
        power_up(4'h1, 1'b0);
        p0 = sent;
        run = 1'b1;
        step(40);
        run = 1'b0;
        step(8);
        chk(position_count, sent - p0);
        p1 = sent;
        ref_dir_in = 1'b1;
        run = 1'b1;
        step(30);
        run = 1'b0;
        step(8);
        chk(position_count, 2 * p1 - p0 - sent);
        chk(active_loop, 3'h1);
        step(20);
        $display("test position done");
        power_up(4'h2, 1'b0);
        run = 1'b1;
        step(8);
        chk(active_loop, 3'h3);
        chk(torque_command, analog_torque_ref);
        power_up(4'h3, 1'b0);
        step(8);
        chk(active_loop, 3'h2);
        chk(speed_command, 16'h0000);
        for (int k = 1; k <= 3; k++) begin
            fwd_current_limit_in = ~k[1];
            rev_current_limit_in = ~k[0];
            exp_speed = k == 1 ? preset_speed_1 : k == 2 ? preset_speed_2 : preset_speed_3;
            step(6);
            chk(speed_command, exp_speed);
        end
        prop_control_in = 1'b0;
        step(6);
        chk(speed_command, 16'(16'h0000 - preset_speed_3));
        {prop_control_in, fwd_current_limit_in, rev_current_limit_in} = 3'h7;
        $display("test basic modes done");
        for (int m = 4; m <= 14; m++) begin
            power_up(4'(m), 1'b0);
            for (int s = 0; s < 2; s++) begin
                mode_switch_in = s[0];
                step(8);
                chk(active_loop, {1'b0, m[1], m[1] ^ m[0] ^ s[0]});
            end
        end
        run = 1'b0;
        step(20);
        $display("test switching done");
        power_up(4'h0, 1'b1);
        step(8);
        chk(motor_power_on, 1'b1);
        {enable_source_param, control_mode_param} = 5'h02;
        step(8);
        chk(motor_power_on, 1'b1);
        chk(active_loop, 3'h0);
        drive_ready = 1'b0;
        step(4);
        chk(motor_power_on, 1'b0);
        drive_ready = 1'b1;
        power_up(4'h2, 1'b0);
        step(8);
        chk(motor_power_on, 1'b0);
        $display("test enable source done");
        report_and_stop();
    end
endmodule : smse_top_bench
